// File: include/card_cmd_defs_defs.vh
`ifndef CARD_CMD_DEFS_DEFS_VH
`define CARD_CMD_DEFS_DEFS_VH

// ==========================================================
// Frame layout
`define FRAME_BITS 48
`define FRAME_START_BIT 47
`define FRAME_TRANS_BIT 46
`define FRAME_IDX_HI 45
`define FRAME_IDX_LO 40
`define FRAME_ARG_HI 39
`define FRAME_ARG_LO 8
`define FRAME_CRC_HI 7
`define FRAME_CRC_LO 1
`define FRAME_END_BIT 0
`define CRC7_POLY 7'h09

// ==========================================================
// Command indices
`define IDX_RESET 6'h00
`define IDX_INIT_START 6'h01
`define IDX_SPEC_DATA 6'h09
`define IDX_IDENT 6'h0A
`define IDX_STOP 6'h0C
`define IDX_STATUS 6'h0D
`define IDX_BLOCK_LEN 6'h10
`define IDX_READ_SINGLE 6'h11
`define IDX_READ_MULTI 6'h12
`define IDX_BLOCK_COUNT 6'h17
`define IDX_LOCK 6'h2A
`define IDX_OP_COND_READ 6'h3A

// ==========================================================
// First response byte bit positions
`define R1_IDLE 0
`define R1_CRC_ERR 3
`define R1_ILLEGAL 2
`define R1_PARAM_ERR 6

// ==========================================================
// Response lengths in bits, one filler byte included
`define RESP_LEN_R1 6'd16
`define RESP_LEN_R2 6'd24
`define RESP_LEN_R3 6'd48
`define RESP_FILL 8'hFF

// ==========================================================
// Reset values and timing
`define BLOCK_LEN_RST 32'h00000200
`define CLK_MHZ 20
`define INIT_TIME_US 1000
`define LOCK_TIME_US 500

`endif

// File: logic/crc7_unit.v
`timescale 1ns/100ps
`include "card_cmd_defs_defs.vh"

module crc7_unit #(
   parameter WIDTH = 40
) (
   input wire [WIDTH-1:0] data,
   output reg [6:0] crc
);

   integer i;
   reg fb;

   // ==========================================================
   // Serial CRC7 over the data, MSB first
   always @* begin
      crc = 7'h00;
      fb = 1'b0;
      for (i = WIDTH - 1; i >= 0; i = i - 1) begin
         fb = data[i] ^ crc[6];
         crc = {crc[5:0], 1'b0};
         if (fb) begin
            crc = crc ^ `CRC7_POLY;
         end
      end
   end

endmodule // crc7_unit

// File: logic/card_spi_command_decoder.v
// Notes on behaviour
// - A command frame is exactly six bytes; decoding happens on 48 bits.
// - Frame bits arrive MSB first and are assembled in that order.
// - Start 0, transmission 1, index, argument, CRC7, end bit 1.
// - Every frame carries a CRC7 before the end bit; card checks it.
// - Index field holds the command number in plain binary.
// - Only supported low indices accepted; 2,3,4,7,11,15,20 rejected.
// - Reserved indices 5,6,8,14,19,21,22 never execute.
// - Index 0 resets, index 1 starts initialisation; both answer R1.
// - Index 9 requests card specific data, answers R1.
// - Index 10 requests card identification, answers R1.
// - Index 12 ends a multiple block read, answers R1.
// - Index 13 answers two-byte R2 with status.
// - Index 16 sets block length from the full argument, answers R1.
// - Index 17 reads one block at the argument address, answers R1.
// - Index 18 starts multiple block read until stop or count.
// - Index 23 count applies only if index 18 is the next accepted command.
// - Lock command answers R1 then busy.
// - R1b is R1 followed by busy until the operation completes.
// - Busy holds the serial output low, then releases it.
// - In idle only reset, initialisation and conditions read are accepted.
`timescale 1ns/100ps
`include "card_cmd_defs_defs.vh"

module card_spi_command_decoder #(
   parameter integer INIT_CYCLES = `INIT_TIME_US * `CLK_MHZ,
   parameter integer BUSY_CYCLES = `LOCK_TIME_US * `CLK_MHZ,
   parameter [31:0] DEFAULT_BLOCK_LEN = `BLOCK_LEN_RST,
   parameter [31:0] OP_COND_VALUE = 32'h00FF8000
) (
   input wire sys_clk,
   input wire nrst,
   input wire link_clk,
   input wire chip_sel_n,
   input wire serial_in_line,
   output reg serial_out_line,
   output reg serial_out_oe,
   output reg card_reset,
   output reg idle_state,
   output reg busy,
   output reg spec_data_read,
   output reg ident_read,
   output reg stop_read,
   output reg read_start,
   output reg read_multi,
   output reg read_counted,
   output reg [31:0] read_addr,
   output reg [31:0] block_len,
   output reg [15:0] block_count,
   output reg count_valid,
   output reg lock_start
);

   // ==========================================================
   // Reset release and input synchronisers
   reg rst_q1;
   reg rst_q2;
   reg [2:0] sync1;
   reg [2:0] sync2;
   reg sck_d;
   wire rst_n;
   wire sck_rise;
   wire sck_fall;
   wire sel;
   wire din;

   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         rst_q1 <= 1'b0;
         rst_q2 <= 1'b0;
      end else begin
         rst_q1 <= 1'b1;
         rst_q2 <= rst_q1;
      end
   end
   assign rst_n = rst_q2;

   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sync1 <= 3'h3;
         sync2 <= 3'h3;
         sck_d <= 1'b0;
      end else begin
         sync1 <= {link_clk, chip_sel_n, serial_in_line};
         sync2 <= sync1;
         sck_d <= sync2[2];
      end
   end
   assign sck_rise = sync2[2] & ~sck_d;
   assign sck_fall = ~sync2[2] & sck_d;
   assign sel = ~sync2[1];
   assign din = sync2[0];

   // ==========================================================
   // Frame capture
   reg [47:0] frame;
   reg [5:0] rx_cnt;
   reg frame_ready;
   reg tx_active;
   wire [6:0] crc_calc;

   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         frame <= 48'hFFFFFFFFFFFF;
         rx_cnt <= 6'd0;
         frame_ready <= 1'b0;
      end else begin
         frame_ready <= 1'b0;
         if (!sel) begin
            frame <= 48'hFFFFFFFFFFFF;
            rx_cnt <= 6'd0;
         end else if (sck_rise && !tx_active && !frame_ready) begin
            frame <= {frame[46:0], din};
            if (rx_cnt == 6'd0) begin
               if (!frame[0] && din) begin
                  rx_cnt <= 6'd2;
               end
            end else if (rx_cnt == 6'd47) begin
               rx_cnt <= 6'd0;
               frame_ready <= 1'b1;
            end else begin
               rx_cnt <= rx_cnt + 6'd1;
            end
         end
      end
   end

   crc7_unit #(
      .WIDTH(40)
   ) u_crc (
      .data(frame[`FRAME_START_BIT:`FRAME_ARG_LO]),
      .crc(crc_calc)
   );

   // ==========================================================
   // Command decode
   wire [5:0] cmd_idx = frame[`FRAME_IDX_HI:`FRAME_IDX_LO];
   wire [31:0] cmd_arg = frame[`FRAME_ARG_HI:`FRAME_ARG_LO];
   reg supported;
   reg crc_err;
   reg illegal;
   reg param_err;
   reg accept;
   reg [7:0] r1;
   reg [5:0] next_tx_len;
   reg [39:0] next_tx_ext;

   always @* begin
      case (cmd_idx)
         `IDX_RESET, `IDX_INIT_START, `IDX_SPEC_DATA, `IDX_IDENT,
         `IDX_STOP, `IDX_STATUS, `IDX_BLOCK_LEN, `IDX_READ_SINGLE,
         `IDX_READ_MULTI, `IDX_BLOCK_COUNT, `IDX_LOCK,
         `IDX_OP_COND_READ: supported = 1'b1;
         default: supported = 1'b0;
      endcase
      crc_err = (crc_calc != frame[`FRAME_CRC_HI:`FRAME_CRC_LO])
         | ~frame[`FRAME_END_BIT] | frame[`FRAME_START_BIT]
         | ~frame[`FRAME_TRANS_BIT];
      illegal = ~supported | busy
         | (idle_state && cmd_idx != `IDX_RESET
            && cmd_idx != `IDX_INIT_START
            && cmd_idx != `IDX_OP_COND_READ);
      param_err = (cmd_idx == `IDX_BLOCK_COUNT)
         && (cmd_arg[31:16] != 16'h0000);
      accept = ~crc_err & ~illegal & ~param_err;
      r1 = 8'h00;
      r1[`R1_IDLE] = idle_state | (accept && cmd_idx == `IDX_RESET);
      r1[`R1_CRC_ERR] = crc_err;
      r1[`R1_ILLEGAL] = illegal & ~crc_err;
      r1[`R1_PARAM_ERR] = param_err & ~crc_err & ~illegal;
      next_tx_len = `RESP_LEN_R1;
      next_tx_ext = {r1, 32'h00000000};
      if (!crc_err && !illegal && cmd_idx == `IDX_STATUS) begin
         next_tx_len = `RESP_LEN_R2;
         next_tx_ext = {r1, 7'h00, busy, 24'h000000};
      end else if (!crc_err && !illegal && cmd_idx == `IDX_OP_COND_READ) begin
         next_tx_len = `RESP_LEN_R3;
         next_tx_ext = {r1, OP_COND_VALUE};
      end
   end

   // ==========================================================
   // Response shifter, busy and command effects
   reg [47:0] tx_sr;
   reg [5:0] tx_len;
   reg [5:0] tx_cnt;
   reg busy_pending;
   reg init_run;
   reg [31:0] init_cnt;
   reg [31:0] busy_cnt;

   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_sr <= 48'hFFFFFFFFFFFF;
         tx_len <= 6'd0;
         tx_cnt <= 6'd0;
         tx_active <= 1'b0;
         busy_pending <= 1'b0;
         busy <= 1'b0;
         busy_cnt <= 32'h00000000;
         init_run <= 1'b0;
         init_cnt <= 32'h00000000;
         idle_state <= 1'b1;
         card_reset <= 1'b0;
         spec_data_read <= 1'b0;
         ident_read <= 1'b0;
         stop_read <= 1'b0;
         read_start <= 1'b0;
         read_multi <= 1'b0;
         read_counted <= 1'b0;
         read_addr <= 32'h00000000;
         block_len <= DEFAULT_BLOCK_LEN;
         block_count <= 16'h0000;
         count_valid <= 1'b0;
         lock_start <= 1'b0;
         serial_out_line <= 1'b1;
         serial_out_oe <= 1'b0;
      end else begin
         card_reset <= 1'b0;
         spec_data_read <= 1'b0;
         ident_read <= 1'b0;
         stop_read <= 1'b0;
         read_start <= 1'b0;
         lock_start <= 1'b0;
         if (init_run) begin
            if (init_cnt == INIT_CYCLES - 1) begin
               init_run <= 1'b0;
               idle_state <= 1'b0;
            end else begin
               init_cnt <= init_cnt + 32'h00000001;
            end
         end
         if (busy) begin
            if (busy_cnt == BUSY_CYCLES - 1) begin
               busy <= 1'b0;
            end else begin
               busy_cnt <= busy_cnt + 32'h00000001;
            end
         end
         if (!sel) begin
            tx_active <= 1'b0;
         end else if (tx_active && sck_fall) begin
            tx_sr <= {tx_sr[46:0], 1'b1};
            if (tx_cnt == tx_len - 6'd1) begin
               tx_active <= 1'b0;
            end else begin
               tx_cnt <= tx_cnt + 6'd1;
            end
         end
         if (busy_pending && !tx_active) begin
            busy_pending <= 1'b0;
            busy <= 1'b1;
            busy_cnt <= 32'h00000000;
         end
         if (frame_ready) begin
            tx_sr <= {`RESP_FILL, next_tx_ext};
            tx_len <= next_tx_len;
            tx_cnt <= 6'd0;
            // No response while busy, line held low
            tx_active <= ~busy;
            if (accept) begin
               if (cmd_idx != `IDX_BLOCK_COUNT) begin
                  count_valid <= 1'b0;
               end
               case (cmd_idx)
                  `IDX_RESET: begin
                     card_reset <= 1'b1;
                     idle_state <= 1'b1;
                     init_run <= 1'b0;
                  end
                  `IDX_INIT_START: begin
                     if (idle_state && !init_run) begin
                        init_run <= 1'b1;
                        init_cnt <= 32'h00000000;
                     end
                  end
                  `IDX_SPEC_DATA: spec_data_read <= 1'b1;
                  `IDX_IDENT: ident_read <= 1'b1;
                  `IDX_STOP: stop_read <= 1'b1;
                  `IDX_BLOCK_LEN: block_len <= cmd_arg;
                  `IDX_READ_SINGLE: begin
                     read_start <= 1'b1;
                     read_multi <= 1'b0;
                     read_counted <= 1'b0;
                     read_addr <= cmd_arg;
                  end
                  `IDX_READ_MULTI: begin
                     read_start <= 1'b1;
                     read_multi <= 1'b1;
                     read_counted <= count_valid;
                     read_addr <= cmd_arg;
                  end
                  `IDX_BLOCK_COUNT: begin
                     block_count <= cmd_arg[15:0];
                     count_valid <= 1'b1;
                  end
                  `IDX_LOCK: begin
                     lock_start <= 1'b1;
                     busy_pending <= 1'b1;
                  end
                  default: begin
                  end
               endcase
            end
         end
         serial_out_oe <= sel;
         if (tx_active) begin
            serial_out_line <= tx_sr[47];
         end else begin
            serial_out_line <= ~(busy | busy_pending);
         end
      end
   end

endmodule // card_spi_command_decoder

// File: verification/card_cmd_asserts.sv
`timescale 1ns/100ps
module card_cmd_asserts #(
   parameter integer BUSY_CYCLES = 20
) (
   input wire sys_clk,
   input wire nrst,
   input wire chip_sel_n,
   input wire serial_out_line,
   input wire serial_out_oe,
   input wire card_reset,
   input wire idle_state,
   input wire busy,
   input wire spec_data_read,
   input wire ident_read,
   input wire stop_read,
   input wire read_start,
   input wire read_multi,
   input wire read_counted,
   input wire count_valid,
   input wire lock_start
);
   wire [4:0] cmd_fx = {spec_data_read, ident_read, stop_read, read_start,
      lock_start};
   logic [15:0] busy_cnt;
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!nrst);
   // =====
   // Busy length counter
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst)
         busy_cnt <= 16'h0000;
      else
         busy_cnt <= busy ? busy_cnt + 16'h0001 : 16'h0000;
   end
   sequence s_busy_hold;
      busy [*8];
   endsequence
   sequence s_lock_busy;
      ##[1:600] busy;
   endsequence
   AST_ONE_EFFECT: assert property (
      $onehot0({card_reset, cmd_fx}))
      else $error("effects overlap");
   AST_RESET_IDLE: assert property (
      card_reset |-> ##[0:1] idle_state)
      else $error("no idle after reset");
   AST_IDLE_GATE: assert property (
      idle_state && $past(idle_state) |-> cmd_fx == 5'h00)
      else $error("command ran in idle");
   AST_READ_KIND: assert property (
      $changed(read_multi) |-> read_start)
      else $error("read kind moved alone");
   AST_COUNTED: assert property (
      read_start && read_counted |-> read_multi && $past(count_valid))
      else $error("counted read without count");
   AST_BUSY_LOW: assert property (
      busy && $past(busy) && serial_out_oe && $past(serial_out_oe)
      |-> !serial_out_line)
      else $error("line high while busy");
   AST_BUSY_HOLD: assert property (
      $rose(busy) |-> s_busy_hold)
      else $error("busy too short");
   AST_BUSY_LEN: assert property (
      $fell(busy) |-> busy_cnt >= BUSY_CYCLES - 2
      && busy_cnt <= BUSY_CYCLES + 2)
      else $error("busy length wrong");
   AST_LOCK_BUSY: assert property (
      lock_start |-> s_lock_busy)
      else $error("no busy after lock");
   AST_DESELECT: assert property (
      chip_sel_n [*8] |-> !serial_out_oe)
      else $error("driving while deselected");
endmodule // card_cmd_asserts

// File: verification/host_model.sv
`timescale 1ns/100ps
module host_model (
   input wire sys_clk,
   output logic link_clk,
   output logic chip_sel_n,
   output logic serial_in_line,
   input wire serial_out_line,
   input wire serial_out_oe
);
   // =====
   // Pull-up holds a released card output high
   wire miso = serial_out_oe ? serial_out_line : 1'h1;
   initial begin
      link_clk = 1'h0;
      chip_sel_n = 1'h1;
      serial_in_line = 1'h1;
   end
   function automatic logic [6:0] crc7(input logic [39:0] d);
      logic [6:0] c;
      c = 7'h00;
      for (int i = 39; i >= 0; i--)
         c = {c[5:0], 1'h0} ^ ((d[i] ^ c[6]) ? 7'h09 : 7'h00);
      return c;
   endfunction
   // Drive on the falling edge, read late in the high phase
   task automatic bit_x(input logic b, output logic r);
      @(posedge sys_clk);
      serial_in_line <= b;
      link_clk <= 1'h0;
      repeat (4) @(posedge sys_clk);
      link_clk <= 1'h1;
      repeat (3) @(posedge sys_clk);
      @(negedge sys_clk);
      r = miso;
   endtask
   task automatic xfer(input logic [5:0] idx, input logic [31:0] arg,
      input logic bad, input int n, output logic [39:0] resp);
      logic [47:0] f;
      logic r;
      int i;
      f[47:8] = {2'h1, idx, arg};
      f[7:0] = {crc7(f[47:8]) ^ {6'h00, bad}, 1'h1};
      resp = 40'h0;
      chip_sel_n <= 1'h0;
      for (i = 0; i < 8; i++)
         bit_x(1'h1, r);
      for (i = 47; i >= 0; i--)
         bit_x(f[i], r);
      for (i = 0; i < 16 && r; i++)
         bit_x(1'h1, r);
      resp[0] = r;
      for (i = 1; i < n * 8; i++) begin
         bit_x(1'h1, r);
         resp = {resp[38:0], r};
      end
      @(posedge sys_clk);
      link_clk <= 1'h0;
      repeat (2) @(posedge sys_clk);
      chip_sel_n <= 1'h1;
      repeat (4) @(posedge sys_clk);
   endtask
endmodule // host_model

// File: verification/tb_top.sv
`timescale 1ns/100ps
module tb_top;
   typedef struct packed {
      logic [5:0] idx;
      logic [31:0] arg;
      logic [7:0] r1;
      logic [5:0] fx;
      logic rc;
   } row_t;
   logic sys_clk = 1'h0;
   logic nrst = 1'h0;
   wire link_clk, chip_sel_n, serial_in_line, serial_out_line, serial_out_oe;
   wire card_reset, idle_state, busy, spec_data_read, ident_read, stop_read;
   wire read_start, read_multi, read_counted, count_valid, lock_start;
   wire [31:0] read_addr, block_len;
   wire [15:0] block_count;
   logic [5:0] fx_seen;
   logic fx_clr = 1'h1;
   logic [39:0] resp;
   int num_errors = 0;
   int compares = 0;
   int i;
   row_t rows [9] = '{
      '{6'h09, 32'h0, 8'h00, 6'h10, 1'h0},
      '{6'h0A, 32'h0, 8'h00, 6'h08, 1'h0},
      '{6'h0C, 32'h0, 8'h00, 6'h04, 1'h0},
      '{6'h10, 32'h40, 8'h00, 6'h00, 1'h0},
      '{6'h11, 32'h12345678, 8'h00, 6'h02, 1'h0},
      '{6'h17, 32'h5, 8'h00, 6'h00, 1'h0},
      '{6'h12, 32'hA000, 8'h00, 6'h02, 1'h1},
      '{6'h12, 32'hB000, 8'h00, 6'h02, 1'h0},
      '{6'h17, 32'h10003, 8'h40, 6'h00, 1'h0}};
   logic [5:0] bad_idx [14] = '{6'h02, 6'h03, 6'h04, 6'h07, 6'h0B, 6'h0F,
      6'h14, 6'h05, 6'h06, 6'h08, 6'h0E, 6'h13, 6'h15, 6'h16};
   always #25 sys_clk = ~sys_clk;
   // =====
   // Sticky record of effect pulses
   always @(posedge sys_clk) begin
      if (fx_clr)
         fx_seen <= 6'h00;
      else
         fx_seen <= fx_seen | {card_reset, spec_data_read, ident_read,
            stop_read, read_start, lock_start};
   end
   card_spi_command_decoder #(.INIT_CYCLES(20), .BUSY_CYCLES(2000),
      .OP_COND_VALUE(32'h00FF8000)) i_dut (
      .sys_clk(sys_clk), .nrst(nrst), .link_clk(link_clk),
      .chip_sel_n(chip_sel_n), .serial_in_line(serial_in_line),
      .serial_out_line(serial_out_line), .serial_out_oe(serial_out_oe),
      .card_reset(card_reset), .idle_state(idle_state), .busy(busy),
      .spec_data_read(spec_data_read), .ident_read(ident_read),
      .stop_read(stop_read),
      .read_start(read_start), .read_multi(read_multi),
      .read_counted(read_counted), .read_addr(read_addr),
      .block_len(block_len), .block_count(block_count),
      .count_valid(count_valid), .lock_start(lock_start));
   host_model i_host (.sys_clk(sys_clk), .link_clk(link_clk),
      .chip_sel_n(chip_sel_n), .serial_in_line(serial_in_line),
      .serial_out_line(serial_out_line), .serial_out_oe(serial_out_oe));
   task chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task chk_resp(input logic [15:0] exp);
      chk({16'h0000, resp[15:0]}, {16'h0000, exp});
   endtask
   task run(input logic [5:0] idx, input logic [31:0] arg,
      input logic bad, input int n);
      @(posedge sys_clk);
      fx_clr <= 1'h1;
      @(posedge sys_clk);
      fx_clr <= 1'h0;
      i_host.xfer(idx, arg, bad, n, resp);
   endtask
   task finish_test;
      $display("compares %0d errors %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (60000) @(posedge sys_clk);
      num_errors++;
      $display("watchdog ran out");
      finish_test;
   end
   initial begin
      repeat (12) @(posedge sys_clk);
      chk(idle_state, 32'h1);
      chk(block_len, 32'h200);
      chk(serial_out_oe, 32'h0);
      nrst <= 1'h1;
      repeat (20) @(posedge sys_clk);
      run(6'h09, 32'h0, 1'h0, 1);
      chk_resp(16'h05);
      chk(fx_seen, 32'h0);
      run(6'h00, 32'h0, 1'h0, 1);
      chk_resp(16'h01);
      chk(fx_seen, 32'h20);
      for (i = 0; i < 4 && resp[0] !== 1'h0; i++)
         run(6'h01, 32'h0, 1'h0, 1);
      chk_resp(16'h00);
      chk(idle_state, 32'h0);
      $display("test reset and init done");
      foreach (rows[k]) begin
         run(rows[k].idx, rows[k].arg, 1'h0, 1);
         chk_resp({8'h00, rows[k].r1});
         chk(fx_seen, rows[k].fx);
         chk(read_counted, rows[k].rc);
      end
      chk(block_len, 32'h40);
      chk(read_addr, 32'hB000);
      chk(read_multi, 32'h1);
      chk(block_count, 32'h5);
      chk(count_valid, 32'h0);
      $display("test command table done");
      foreach (bad_idx[k]) begin
         run(bad_idx[k], 32'h0, 1'h0, 1);
         chk_resp(16'h04);
         chk(fx_seen, 32'h0);
      end
      run(6'h09, 32'h0, 1'h1, 1);
      chk_resp(16'h08);
      chk(fx_seen, 32'h0);
      $display("test refused commands done");
      run(6'h0D, 32'h0, 1'h0, 2);
      chk_resp(16'h0000);
      run(6'h2A, 32'h0, 1'h0, 2);
      chk_resp(16'h0000);
      chk(fx_seen, 32'h01);
      chk(busy, 32'h1);
      run(6'h00, 32'h0, 1'h0, 1);
      chk_resp(16'h0000);
      chk(fx_seen, 32'h0);
      chk(idle_state, 32'h0);
      chk(busy, 32'h1);
      for (i = 0; i < 2000 && busy !== 1'h0; i++)
         @(posedge sys_clk);
      chk(busy, 32'h0);
      run(6'h0D, 32'h0, 1'h0, 2);
      chk_resp(16'h0000);
      run(6'h00, 32'h0, 1'h0, 1);
      chk(idle_state, 32'h1);
      run(6'h3A, 32'h0, 1'h0, 5);
      chk({24'h000000, resp[39:32]}, 32'h1);
      chk(resp[31:0], 32'h00FF8000);
      $display("test status lock and reset done");
      finish_test;
   end
endmodule // tb_top
bind card_spi_command_decoder card_cmd_asserts #(.BUSY_CYCLES(BUSY_CYCLES))
   i_chk (.sys_clk(sys_clk), .nrst(nrst), .chip_sel_n(chip_sel_n),
   .serial_out_line(serial_out_line), .serial_out_oe(serial_out_oe),
   .card_reset(card_reset), .idle_state(idle_state), .busy(busy),
   .spec_data_read(spec_data_read), .ident_read(ident_read),
   .stop_read(stop_read),
   .read_start(read_start), .read_multi(read_multi),
   .read_counted(read_counted), .count_valid(count_valid),
   .lock_start(lock_start));
